// *** include/rate_change_params.svh ***
// constants for the sample-rate change sequencer
// Overview of operation
// - After a clock selection change the device resynchronises and drops every host write.
// - While resynchronising every host read returns the busy byte 80h.
// - With calibrate-on-exit set the host polls calibration-in-progress, held for 128 samples.
// - The device drives the external transceiver enable and direction itself.
// - Leaving the gate with calibrate-on-exit set and no resync running starts calibration, else offsets are kept.
// - Calibration-in-progress rises within five sample periods of the gate closing.
// - Transfers enabled during calibration do not begin until it completes.
`ifndef RATE_CHANGE_PARAMS_SVH
`define RATE_CHANGE_PARAMS_SVH
`define BUSY_BYTE          8'h80
`define RESYNC_SAMPLES     4
`define CAL_SAMPLES        128
`define CAL_START_SAMPLES  2
`define CAL_START_LIMIT    5
`define DIVIDER_RESET      3'h0
`define SOURCE_RESET       1'b0
`endif

// *** include/rate_change_pkg.sv ***
// types for the sample-rate change sequencer
package rate_change_pkg;
   typedef struct packed {
      logic cs_b;
      logic rd_b;
      logic wr_b;
   } host_strobe_t;

   typedef struct packed {
      logic       clock_source_select;
      logic [2:0] rate_divider_select;
   } clock_sel_t;

   typedef enum logic [1:0] {
      S_IDLE,
      S_RESYNC,
      S_CAL_WAIT,
      S_CAL
   } seq_state_t;
endpackage

// *** design/sample_rate_change_sequencer.sv ***
// sample-rate change sequencer: resync, busy reads, autocalibration, transceiver control
`timescale 1ns/1ps
`include "rate_change_params.svh"
module sample_rate_change_sequencer
   import rate_change_pkg::*;
#(
   parameter int RESYNC_SAMPLES    = `RESYNC_SAMPLES,
   parameter int CAL_SAMPLES       = `CAL_SAMPLES,
   parameter int CAL_START_SAMPLES = `CAL_START_SAMPLES
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_b,
   input  wire host_strobe_t host_strobe,
   input  wire logic [7:0]   reg_rd_data,
   input  wire logic         mode_change_gate,
   input  wire logic         calibrate_on_exit,
   input  wire logic         sel_wr,
   input  wire clock_sel_t   sel_data,
   input  wire logic         sample_tick,
   input  wire logic         xfer_enable,
   output logic [7:0]        host_rd_data,
   output logic              data_oe_b,
   output logic              xcvr_en_b,
   output logic              xcvr_dir,
   output logic              wr_accept,
   output clock_sel_t        clock_sel,
   output logic              resync_busy,
   output logic              calibration_in_progress,
   output logic              xfer_run
);
   initial begin
      if (RESYNC_SAMPLES < 1 || RESYNC_SAMPLES > 511 || CAL_SAMPLES < 1 || CAL_SAMPLES > 511)
         $error("sequencer counts out of range");
      if (CAL_START_SAMPLES < 1 || CAL_START_SAMPLES > `CAL_START_LIMIT)
         $error("calibration start delay out of range");
   end

   // pins are asynchronous: two flops before any use
   host_strobe_t strb_s1_r, strb_s2_r;
   logic         wr_prev_r;
   seq_state_t   state_r, state_nxt;
   logic [8:0]   cnt_r, cnt_nxt;
   logic         gate_prev_r;
   clock_sel_t   clock_sel_nxt;
   logic [7:0]   rd_data_nxt;
   logic         rd_act, wr_act, wr_edge, gate_fell;

   assign rd_act    = !strb_s2_r.cs_b && !strb_s2_r.rd_b;
   assign wr_act    = !strb_s2_r.cs_b && !strb_s2_r.wr_b;
   assign wr_edge   = wr_act && !wr_prev_r;
   assign gate_fell = gate_prev_r && !mode_change_gate;

   always_comb begin
      state_nxt     = state_r;
      cnt_nxt       = cnt_r;
      clock_sel_nxt = clock_sel;
      unique case (state_r)
         S_IDLE: begin
            // selection only moves with the gate open, one write carries both fields
            if (sel_wr && mode_change_gate) begin
               clock_sel_nxt = sel_data;
               if (sel_data != clock_sel) begin
                  state_nxt = S_RESYNC;
                  cnt_nxt   = '0;
               end
            end else if (gate_fell && calibrate_on_exit) begin
               state_nxt = S_CAL_WAIT;
               cnt_nxt   = '0;
            end
         end
         S_RESYNC: begin
            if (sample_tick) begin
               if (cnt_r == 9'(RESYNC_SAMPLES - 1)) begin
                  state_nxt = S_IDLE;
               end else begin
                  cnt_nxt = cnt_r + 9'h001;
               end
            end
         end
         S_CAL_WAIT: begin
            // start well inside the five-sample window
            if (sample_tick) begin
               if (cnt_r == 9'(CAL_START_SAMPLES - 1)) begin
                  state_nxt = S_CAL;
                  cnt_nxt   = '0;
               end else begin
                  cnt_nxt = cnt_r + 9'h001;
               end
            end
         end
         S_CAL: begin
            if (sample_tick) begin
               if (cnt_r == 9'(CAL_SAMPLES - 1)) begin
                  state_nxt = S_IDLE;
               end else begin
                  cnt_nxt = cnt_r + 9'h001;
               end
            end
         end
      endcase
   end

   always_comb begin
      // busy byte hides the register file while clocks settle
      rd_data_nxt = (state_r == S_RESYNC) ? `BUSY_BYTE : reg_rd_data;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         strb_s1_r               <= '1;
         strb_s2_r               <= '1;
         wr_prev_r               <= 1'b0;
         gate_prev_r             <= 1'b0;
         state_r                 <= S_IDLE;
         cnt_r                   <= '0;
         clock_sel               <= '{`SOURCE_RESET, `DIVIDER_RESET};
         host_rd_data            <= '0;
         data_oe_b               <= 1'b1;
         xcvr_en_b               <= 1'b1;
         xcvr_dir                <= 1'b0;
         wr_accept               <= 1'b0;
         resync_busy             <= 1'b0;
         calibration_in_progress <= 1'b0;
         xfer_run                <= 1'b0;
      end else begin
         strb_s1_r               <= host_strobe;
         strb_s2_r               <= strb_s1_r;
         wr_prev_r               <= wr_act;
         gate_prev_r             <= mode_change_gate;
         state_r                 <= state_nxt;
         cnt_r                   <= cnt_nxt;
         clock_sel               <= clock_sel_nxt;
         host_rd_data            <= rd_data_nxt;
         data_oe_b               <= !rd_act;
         xcvr_en_b               <= !(rd_act || wr_act);
         xcvr_dir                <= rd_act;
         wr_accept               <= wr_edge && (state_r != S_RESYNC);
         resync_busy             <= (state_nxt == S_RESYNC);
         calibration_in_progress <= (state_nxt == S_CAL);
         // pending transfers held back until the flag drops
         xfer_run                <= xfer_enable && (state_nxt != S_CAL)
                                    && (state_nxt != S_CAL_WAIT);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   property p_resync_drops_writes;
      (state_r == S_RESYNC) |=> !wr_accept;
   endproperty
   a_resync_drops_writes: assert property (p_resync_drops_writes)
      else $error("write accepted during resync");

   property p_busy_read;
      (rd_act && state_r == S_RESYNC) |=> (host_rd_data == 8'h80) && !data_oe_b;
   endproperty
   a_busy_read: assert property (p_busy_read)
      else $error("read during resync not busy byte");

   property p_xcvr_read;
      rd_act |=> !xcvr_en_b && xcvr_dir;
   endproperty
   a_xcvr_read: assert property (p_xcvr_read)
      else $error("transceiver not set for read");

   property p_cal_held;
      (calibration_in_progress && !(sample_tick && cnt_r == 9'(CAL_SAMPLES - 1)))
         |=> calibration_in_progress;
   endproperty
   a_cal_held: assert property (p_cal_held)
      else $error("calibration flag dropped early");

   property p_no_cal_without_flag;
      (gate_fell && !calibrate_on_exit && state_r == S_IDLE && !sel_wr) |=> state_r == S_IDLE;
   endproperty
   a_no_cal_without_flag: assert property (p_no_cal_without_flag)
      else $error("calibration started without calibrate on exit");

   property p_cal_start_bound;
      (state_r == S_CAL_WAIT) |-> cnt_r < 9'(`CAL_START_LIMIT);
   endproperty
   a_cal_start_bound: assert property (p_cal_start_bound)
      else $error("calibration start exceeded five samples");

   property p_xfer_held;
      xfer_run |-> !calibration_in_progress && state_r != S_CAL_WAIT;
   endproperty
   a_xfer_held: assert property (p_xfer_held)
      else $error("transfer ran during calibration");

   property p_cal_full_length;
      $fell(calibration_in_progress) |-> $past(cnt_r) == 9'(CAL_SAMPLES - 1);
   endproperty
   a_cal_full_length: assert property (p_cal_full_length)
      else $error("calibration flag cleared before completion");

   property p_busy_all_reads;
      (state_r == S_RESYNC) |=> host_rd_data == `BUSY_BYTE;
   endproperty
   a_busy_all_reads: assert property (p_busy_all_reads)
      else $error("read data not busy byte during resync");

   property p_sel_closed_ignored;
      (sel_wr && !mode_change_gate) |=> $stable(clock_sel);
   endproperty
   a_sel_closed_ignored: assert property (p_sel_closed_ignored)
      else $error("selection changed with gate closed");

   property p_xcvr_write;
      (wr_act && !rd_act) |=> !xcvr_en_b && !xcvr_dir && data_oe_b;
   endproperty
   a_xcvr_write: assert property (p_xcvr_write)
      else $error("transceiver not set for write");

   // an idle bus must never see the data lines driven
   property p_xcvr_idle;
      (!rd_act && !wr_act) |=> xcvr_en_b && data_oe_b;
   endproperty
   a_xcvr_idle: assert property (p_xcvr_idle)
      else $error("transceiver enabled with no strobe");

   c_sel_change: cover property ($rose(resync_busy));
   c_resync: cover property ($fell(resync_busy));
   c_cal_done: cover property ($fell(calibration_in_progress));
   c_busy_read: cover property (rd_act && state_r == S_RESYNC);
   c_held_xfer: cover property (xfer_enable && calibration_in_progress);
endmodule // sample_rate_change_sequencer

// *** tb/host_model.sv ***
// host-side model: pin strobes, gate bits and clock selection writes
`timescale 1ns/1ps
module host_model
   import rate_change_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic [7:0]   host_rd_data,
   input  wire logic         calibration_in_progress,
   output host_strobe_t      host_strobe,
   output logic              mode_change_gate,
   output logic              calibrate_on_exit,
   output logic              sel_wr,
   output clock_sel_t        sel_data
);
   initial begin
      host_strobe = 3'h7;
      mode_change_gate = 1'b0;
      calibrate_on_exit = 1'b0;
      sel_wr = 1'b0;
      sel_data = 4'h0;
   end
   // strobe held 4 cycles: one more than the two sync flops and the answer edge need
   task automatic start(input logic rd);
      @(negedge sys_clk);
      host_strobe = rd ? 3'h1 : 3'h2;
      repeat (4) @(negedge sys_clk);
   endtask
   task automatic stop();
      host_strobe = 3'h7;
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic set_gate(input logic g, input logic cal);
      @(negedge sys_clk);
      mode_change_gate = g;
      calibrate_on_exit = cal; // mute and restore stay in the register file
   endtask
   // divider and source always go in one pulse
   task automatic sel_write(input clock_sel_t v);
      @(negedge sys_clk);
      sel_wr = 1'b1;
      sel_data = v;
      @(negedge sys_clk);
      sel_wr = 1'b0;
      sel_data = ~v;
   endtask
   task automatic poll_ready(output logic [7:0] d);
      int n;
      d = 8'h80;
      for (n = 0; n < 50 && d === 8'h80; n++) begin
         start(1'b1);
         d = host_rd_data;
         stop();
      end
   endtask
   task automatic wait_cal(output int n);
      n = 0;
      while (calibration_in_progress === 1'b1 && n < 1000) begin
         @(negedge sys_clk);
         n++;
      end
   endtask
endmodule // host_model

// *** tb/sample_rate_change_sequencer_tb.sv ***
// self-checking bench for the sample-rate change sequencer
`timescale 1ns/1ps
`include "rate_change_params.svh"
module sample_rate_change_sequencer_tb
   import rate_change_pkg::*;
;
   logic         sys_clk = 0, rst_b = 0, sample_tick = 0, xfer_enable = 1;
   logic [7:0]   reg_rd_data = 8'h00, d, host_rd_data;
   logic         mode_change_gate, calibrate_on_exit, sel_wr, resync_busy;
   logic         data_oe_b, xcvr_en_b, xcvr_dir, wr_accept, calibration_in_progress, xfer_run;
   host_strobe_t host_strobe;
   clock_sel_t   sel_data, clock_sel;
   int           miscompares = 0, comparisons = 0, accepts = 0, n;
   logic [1:0]   tick_cnt = 2'h0;
   typedef struct packed { logic rd; logic [7:0] din; } row_t;
   row_t         rows [4] = '{'{1'b1, 8'h5a}, '{1'b0, 8'h00}, '{1'b1, 8'ha5}, '{1'b1, 8'hff}};
   always #2.5 sys_clk = ~sys_clk;
   // short sample period keeps the run brief
   always @(negedge sys_clk) begin
      tick_cnt <= tick_cnt + 2'h1;
      sample_tick <= (tick_cnt == 2'h3);
   end
   always @(posedge sys_clk) if (wr_accept === 1'b1) accepts++;
   sample_rate_change_sequencer dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .host_strobe(host_strobe), .reg_rd_data(reg_rd_data),
      .mode_change_gate(mode_change_gate), .calibrate_on_exit(calibrate_on_exit),
      .sel_wr(sel_wr), .sel_data(sel_data), .sample_tick(sample_tick),
      .xfer_enable(xfer_enable), .host_rd_data(host_rd_data), .data_oe_b(data_oe_b),
      .xcvr_en_b(xcvr_en_b), .xcvr_dir(xcvr_dir), .wr_accept(wr_accept), .clock_sel(clock_sel),
      .resync_busy(resync_busy), .calibration_in_progress(calibration_in_progress),
      .xfer_run(xfer_run));
   host_model host (
      .sys_clk(sys_clk), .host_rd_data(host_rd_data),
      .calibration_in_progress(calibration_in_progress), .host_strobe(host_strobe),
      .mode_change_gate(mode_change_gate), .calibrate_on_exit(calibrate_on_exit),
      .sel_wr(sel_wr), .sel_data(sel_data));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #20000;
      miscompares++;
      final_report;
   end
   initial begin
      repeat (4) @(negedge sys_clk);
      rst_b = 1'b1;
      @(negedge sys_clk);
      chk({clock_sel, resync_busy, calibration_in_progress, data_oe_b, xcvr_en_b}, 8'h03);
      foreach (rows[i]) begin
         reg_rd_data = rows[i].din;
         n = accepts;
         host.start(rows[i].rd);
         chk({data_oe_b, xcvr_en_b, xcvr_dir}, {~rows[i].rd, 1'b0, rows[i].rd});
         if (rows[i].rd) chk(host_rd_data, rows[i].din);
         host.stop();
         chk(8'(accepts - n), {7'h0, ~rows[i].rd});
      end
      // a selection write with the gate closed must leave the clocks alone
      host.sel_write(4'hd);
      chk(clock_sel, 4'h0);
      host.set_gate(1'b1, 1'b1);
      host.sel_write(4'hd);
      chk({clock_sel, resync_busy}, 8'h1b);
      reg_rd_data = 8'h3c;
      n = accepts;
      host.start(1'b1);
      chk(host_rd_data, 8'h80);
      host.stop();
      host.start(1'b0);
      host.stop();
      chk(8'(accepts - n), 8'h00);
      host.poll_ready(d);
      chk(d, 8'h3c);
      host.set_gate(1'b0, 1'b1);
      repeat (2) @(negedge sys_clk);
      chk(xfer_run, 1'b0);
      n = 0;
      while (calibration_in_progress !== 1'b1 && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      chk(n <= `CAL_START_LIMIT * 4 - 2, 1'b1);
      // enable dropped and raised again while calibrating: must wait for the flag
      xfer_enable = 1'b0;
      @(negedge sys_clk);
      xfer_enable = 1'b1;
      @(negedge sys_clk);
      chk(xfer_run, 1'b0);
      host.wait_cal(n);
      chk(n == `CAL_SAMPLES * 4 - 2, 1'b1);
      @(negedge sys_clk);
      chk(xfer_run, 1'b1);
      host.set_gate(1'b1, 1'b0);
      host.set_gate(1'b0, 1'b0);
      n = 0;
      repeat (40) begin
         @(negedge sys_clk);
         if (calibration_in_progress !== 1'b0 || xfer_run !== 1'b1) n++;
      end
      chk(8'(n), 8'h00);
      // reset in mid-run must clear the selection, the busy and calibration flags and xfer_run, and raise data_oe_b and xcvr_en_b
      rst_b = 1'b0;
      @(negedge sys_clk);
      chk({clock_sel, resync_busy, calibration_in_progress, data_oe_b, xcvr_en_b}, 8'h03);
      chk(xfer_run, 1'b0);
      rst_b = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk(xfer_run, 1'b1);
      xfer_enable = 1'b0;
      @(negedge sys_clk);
      chk(xfer_run, 1'b0);
      final_report;
   end
endmodule // sample_rate_change_sequencer_tb
